/* File: verilog/timer_channel_compare_pwm.sv */
// Timer counter, register file and channel flags driving the compare/PWM pairs
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module timer_channel_compare_pwm (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [chan_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [chan_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [chan_pkg::DATA_W-1:0] reg_rdata,
  output logic [chan_pkg::NUM_CH-1:0] chan_out,
  output logic [chan_pkg::NUM_CH-1:0] chan_oe,
  output logic [chan_pkg::NUM_CH-1:0] chan_irq,
  output logic overflow_flag
);
  import chan_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  timer_ctrl_type ctrl_ff;
  count_type start_ff;
  count_type limit_ff;
  count_type cnt_ff;
  count_type nxt_cnt;
  logic up_ff;
  logic nxt_up;
  logic [NUM_PAIRS*PAIR_W-1:0] pair_ff;
  chan_cfg_type [NUM_CH-1:0] cfg_ff;
  count_type [NUM_CH-1:0] val_ff;
  logic [NUM_CH-1:0] flag_ff;
  logic [NUM_CH-1:0] irq_ff;
  logic ovf_ff;
  logic [DATA_W-1:0] rdata_ff;

  logic ctrl_wr;
  logic status_wr;
  logic start_wr;
  logic limit_wr;
  logic count_wr;
  logic pair_wr;
  logic cfg_sel;
  logic val_sel;
  logic [CH_IDX_W-1:0] ch_idx;
  logic [NUM_CH-1:0] cfg_wr;
  logic [NUM_CH-1:0] val_wr;

  logic free_run;
  count_type eff_limit;
  count_type eff_start;
  logic at_limit;
  logic at_start;
  logic flat;
  logic up_wrap;
  logic center_ovf;
  logic ovf_set;
  logic ovf_clr;
  count_bus_type cbus;

  logic [NUM_CH-1:0] set_flag;
  logic [NUM_CH-1:0] clr_flag;
  logic [NUM_CH-1:0] nxt_flag;
  logic [NUM_CH-1:0] irq_en;
  logic [NUM_CH-1:0] pin_out;
  logic [NUM_CH-1:0] pin_oe;

  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] pair_word;
  logic [DATA_W-1:0] cfg_word [NUM_CH];
  logic [DATA_W-1:0] rd_word;

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  assign ctrl_wr = reg_wr & (reg_addr == A_CTRL);
  assign status_wr = reg_wr & (reg_addr == A_STATUS);
  assign start_wr = reg_wr & (reg_addr == A_START);
  assign limit_wr = reg_wr & (reg_addr == A_LIMIT);
  assign count_wr = reg_wr & (reg_addr == A_COUNT);
  assign pair_wr = reg_wr & (reg_addr == A_PAIR);
  assign cfg_sel = (reg_addr[ADDR_W-1:CH_IDX_W] == A_CH_CFG[ADDR_W-1:CH_IDX_W]);
  assign val_sel = (reg_addr[ADDR_W-1:CH_IDX_W] == A_CH_VAL[ADDR_W-1:CH_IDX_W]);
  assign ch_idx = reg_addr[CH_IDX_W-1:0];

  for (genvar n = 0; n < NUM_CH; n++) begin : g_dec
    assign cfg_wr[n] = reg_wr & cfg_sel & (ch_idx == CH_IDX_W'(n));
    assign val_wr[n] = reg_wr & val_sel & (ch_idx == CH_IDX_W'(n));
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  // Values take effect at once; there is no write buffer, so software should
  // change a PWM value near the period boundary to avoid a stretched pulse.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= '0;
      start_ff <= COUNT_ZERO;
      limit_ff <= COUNT_ZERO;
      pair_ff <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl_ff <= timer_ctrl_type'(reg_wdata[$bits(timer_ctrl_type)-1:0]);
      end
      if (start_wr) begin
        start_ff <= reg_wdata;
      end
      if (limit_wr) begin
        limit_ff <= reg_wdata;
      end
      if (pair_wr) begin
        pair_ff <= reg_wdata[NUM_PAIRS*PAIR_W-1:0];
      end
    end
  end

  for (genvar n = 0; n < NUM_CH; n++) begin : g_chreg
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        cfg_ff[n] <= '0;
        val_ff[n] <= COUNT_ZERO;
      end else begin
        if (cfg_wr[n]) begin
          cfg_ff[n] <= chan_cfg_type'(reg_wdata[CFG_W-1:0]);
        end
        if (val_wr[n]) begin
          val_ff[n] <= reg_wdata;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // With the extended features off, a limit of zero or all ones runs free
  // over the whole range, wrapping from all ones to zero in edge-aligned mode.
  assign free_run = ~ctrl_ff.extended_features_en &
                    ((limit_ff == COUNT_ZERO) | (limit_ff == COUNT_MAX));
  assign eff_limit = free_run ? COUNT_MAX : limit_ff;
  assign eff_start = free_run ? COUNT_ZERO : start_ff;
  assign at_limit = (cnt_ff == eff_limit);
  assign at_start = (cnt_ff == eff_start);
  // Limit equal to start holds the counter; in edge-aligned mode the wrap still fires every clock
  assign flat = (eff_limit == eff_start);

  assign up_wrap = ctrl_ff.run & ~ctrl_ff.center_align_select & at_limit;
  assign center_ovf = ctrl_ff.run & ctrl_ff.center_align_select & up_ff &
                      at_limit & ~flat;
  assign ovf_set = up_wrap | center_ovf;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_up = up_ff;
    if (count_wr) begin
      nxt_cnt = eff_start;
      nxt_up = 1'b1;
    end else if (!ctrl_ff.run) begin
      nxt_cnt = cnt_ff;
    end else if (!ctrl_ff.center_align_select) begin
      nxt_up = 1'b1;
      nxt_cnt = at_limit ? eff_start : cnt_ff + COUNT_ONE;
    end else if (flat) begin
      nxt_cnt = cnt_ff;
    end else if (up_ff) begin
      if (at_limit) begin
        nxt_up = 1'b0;
        nxt_cnt = cnt_ff - COUNT_ONE;
      end else begin
        nxt_cnt = cnt_ff + COUNT_ONE;
      end
    end else begin
      if (at_start) begin
        nxt_up = 1'b1;
        nxt_cnt = cnt_ff + COUNT_ONE;
      end else begin
        nxt_cnt = cnt_ff - COUNT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= COUNT_ZERO;
      up_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      up_ff <= nxt_up;
    end
  end

  assign cbus.cnt = cnt_ff;
  assign cbus.start = eff_start;
  assign cbus.limit = eff_limit;
  assign cbus.up = up_ff;
  assign cbus.tick = ctrl_ff.run & ~count_wr;
  assign cbus.wrap = up_wrap & ~count_wr;
  assign cbus.reinit = count_wr;

  // --------------------------------------------------------------------------
  // Channel pairs
  // --------------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    chan_pair_unit u_pair (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .cbus(cbus),
      .tctrl(ctrl_ff),
      .pcfg(pair_cfg_type'(pair_ff[p*PAIR_W +: PAIR_W])),
      .cfg(cfg_ff[2*p +: 2]),
      .val(val_ff[2*p +: 2]),
      .set_flag(set_flag[2*p +: 2]),
      .out(pin_out[2*p +: 2]),
      .oe(pin_oe[2*p +: 2])
    );
  end

  assign chan_out = pin_out;
  assign chan_oe = pin_oe;

  // --------------------------------------------------------------------------
  // Flags and interrupt requests
  // --------------------------------------------------------------------------
  // Flags clear by writing one; a match in the same cycle keeps the flag set.
  assign clr_flag = status_wr ? reg_wdata[STAT_FLAG_LSB +: NUM_CH] : '0;
  assign ovf_clr = status_wr & reg_wdata[STAT_OVF_BIT];
  assign nxt_flag = (flag_ff & ~clr_flag) | set_flag;

  for (genvar n = 0; n < NUM_CH; n++) begin : g_irq
    assign irq_en[n] = cfg_ff[n].irq_en;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= '0;
      irq_ff <= '0;
      ovf_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      irq_ff <= nxt_flag & irq_en;
      ovf_ff <= (ovf_ff & ~ovf_clr) | ovf_set;
    end
  end

  assign chan_irq = irq_ff;
  assign overflow_flag = ovf_ff;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  assign ctrl_word = DATA_W'(ctrl_ff);
  assign status_word = (DATA_W'(flag_ff) << STAT_FLAG_LSB) | (DATA_W'(ovf_ff) << STAT_OVF_BIT);
  assign pair_word = DATA_W'(pair_ff);

  for (genvar n = 0; n < NUM_CH; n++) begin : g_rd
    assign cfg_word[n] = DATA_W'(cfg_ff[n]) | (DATA_W'(flag_ff[n]) << CFG_FLAG_BIT) |
                         (DATA_W'(pin_out[n]) << CFG_OUT_BIT);
  end

  // Unmapped addresses read as zero
  assign rd_word = (reg_addr == A_CTRL) ? ctrl_word :
                   (reg_addr == A_STATUS) ? status_word :
                   (reg_addr == A_START) ? start_ff :
                   (reg_addr == A_LIMIT) ? limit_ff :
                   (reg_addr == A_COUNT) ? cnt_ff :
                   (reg_addr == A_PAIR) ? pair_word :
                   cfg_sel ? cfg_word[ch_idx] :
                   val_sel ? val_ff[ch_idx] : '0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd ? rd_word : '0;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

/* File: inc/chan_pkg.sv */
// Shared constants, register map and carrier types for the timer channel block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package chan_pkg;

  localparam int NUM_CH = 4;
  localparam int NUM_PAIRS = 2;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int CH_IDX_W = 2;
  localparam int SIGN_BIT = 15;

  // Register map, word addresses
  localparam logic [ADDR_W-1:0] A_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] A_STATUS = 5'h01;
  localparam logic [ADDR_W-1:0] A_START = 5'h02;
  localparam logic [ADDR_W-1:0] A_LIMIT = 5'h03;
  localparam logic [ADDR_W-1:0] A_COUNT = 5'h04;
  localparam logic [ADDR_W-1:0] A_PAIR = 5'h05;
  localparam logic [ADDR_W-1:0] A_CH_CFG = 5'h08;
  localparam logic [ADDR_W-1:0] A_CH_VAL = 5'h0c;

  // Field positions
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_FLAG_LSB = 4;
  localparam int CFG_W = 5;
  localparam int CFG_FLAG_BIT = 5;
  localparam int CFG_OUT_BIT = 6;
  localparam int PAIR_W = 2;

  // Reset values and counter constants
  localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;

  typedef logic [CNT_W-1:0] count_type;

  typedef struct packed {
    logic irq_en;
    logic mode_hi;
    logic mode_lo;
    logic edge_hi;
    logic edge_lo;
  } chan_cfg_type;

  typedef struct packed {
    logic dual_capture_enable;
    logic pair_join;
  } pair_cfg_type;

  typedef struct packed {
    logic extended_features_en;
    logic center_align_select;
    logic run;
  } timer_ctrl_type;

  typedef struct packed {
    count_type cnt;
    count_type start;
    count_type limit;
    logic up;
    logic tick;
    logic wrap;
    logic reinit;
  } count_bus_type;

  typedef enum {
    MODE_OFF,
    MODE_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM,
    MODE_COMBINE
  } chan_mode_type;

endpackage

/* File: verilog/chan_pair_unit.sv */
// One even/odd channel pair: mode decode, match detection and output registers
`timescale 1ns/1ps
module chan_pair_unit (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire chan_pkg::count_bus_type cbus,
  input wire chan_pkg::timer_ctrl_type tctrl,
  input wire chan_pkg::pair_cfg_type pcfg,
  input wire chan_pkg::chan_cfg_type [1:0] cfg,
  input wire chan_pkg::count_type [1:0] val,
  output logic [1:0] set_flag,
  output logic [1:0] out,
  output logic [1:0] oe
);
  import chan_pkg::*;

  logic combine;
  logic [1:0] match;
  logic [1:0] out_ff;

  // --------------------------------------------------------------------------
  // Pair level decode
  // --------------------------------------------------------------------------
  assign combine = tctrl.extended_features_en & pcfg.pair_join &
                   ~pcfg.dual_capture_enable & ~tctrl.center_align_select;
  assign out = out_ff;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    chan_mode_type mode;
    logic drive;
    logic act;
    logic e_zero;
    logic e_full;
    logic e_end;
    logic c_zero;
    logic c_full;
    logic nxt_out;
    logic flag;

    assign mode = pcfg.dual_capture_enable ? MODE_OFF :
                  pcfg.pair_join ? (combine ? MODE_COMBINE : MODE_OFF) :
                  tctrl.center_align_select ? MODE_CENTER_PWM :
                  cfg[i].mode_hi ? MODE_EDGE_PWM :
                  cfg[i].mode_lo ? MODE_COMPARE : MODE_OFF;
    assign match[i] = cbus.tick & (cbus.cnt == val[i]);
    assign drive = cfg[i].edge_hi | cfg[i].edge_lo;
    // Level bits 1:0 give an active-high pulse, X:1 inverts it
    assign act = ~cfg[i].edge_lo;
    assign e_zero = (val[i] == COUNT_ZERO);
    assign e_full = (val[i] > cbus.limit);
    // The output register lags the counter by one clock, so the edge pulse ends as the
    // counter steps onto the value; the width is then value minus start, not one more
    assign e_end = cbus.tick & ~cbus.wrap & ((cbus.cnt + COUNT_ONE) == val[i]);
    assign c_zero = e_zero | val[i][SIGN_BIT];
    assign c_full = ~val[i][SIGN_BIT] & (val[i] >= cbus.limit) & (cbus.limit != COUNT_ZERO);

    always_comb begin
      nxt_out = out_ff[i];
      flag = 1'b0;
      case (mode)
        MODE_COMPARE: begin
          flag = match[i];
          if (match[i]) begin
            case ({cfg[i].edge_hi, cfg[i].edge_lo})
              2'b01: nxt_out = ~out_ff[i];
              2'b10: nxt_out = 1'b0;
              2'b11: nxt_out = 1'b1;
              default: nxt_out = out_ff[i];
            endcase
          end
        end
        MODE_EDGE_PWM: begin
          flag = match[i] & ~e_zero & ~e_full;
          if (e_zero) begin
            nxt_out = ~act;
          end else if (e_full) begin
            nxt_out = act;
          end else if (e_end) begin
            nxt_out = ~act;
          end else if (cbus.wrap) begin
            nxt_out = act;
          end
        end
        MODE_CENTER_PWM: begin
          flag = match[i] & ~c_zero & ~c_full;
          if (c_zero) begin
            nxt_out = ~act;
          end else if (c_full) begin
            nxt_out = act;
          end else if (match[i]) begin
            nxt_out = cbus.up ? ~act : act;
          end
        end
        MODE_COMBINE: begin
          flag = match[i];
          if (i == 0) begin
            // Odd match wins a tie, so equal values give no pulse
            if (match[1]) begin
              nxt_out = ~act;
            end else if (match[0]) begin
              nxt_out = act;
            end else if (cbus.wrap) begin
              nxt_out = ~act;
            end
          end
        end
        default: begin
          nxt_out = out_ff[i];
          flag = 1'b0;
        end
      endcase
      // A counter write restarts the waveform; compare channels keep their level
      if (cbus.reinit && mode != MODE_COMPARE) begin
        nxt_out = 1'b0;
      end
    end

    assign set_flag[i] = flag;
    // The odd output of a combined pair is left to the even one
    assign oe[i] = drive & (mode != MODE_OFF) & ~(mode == MODE_COMBINE && i == 1);

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        out_ff[i] <= 1'b0;
      end else begin
        out_ff[i] <= nxt_out;
      end
    end
  end

endmodule

/* File: tb/chan_pin_model.sv */
// Pin load model: resolves channel pins and counts their high cycles
`timescale 1ns/1ps
module chan_pin_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [chan_pkg::NUM_CH-1:0] chan_out,
  input wire logic [chan_pkg::NUM_CH-1:0] chan_oe,
  output logic [chan_pkg::NUM_CH-1:0] pin_level,
  output logic [chan_pkg::NUM_CH-1:0][15:0] high_cnt
);
  import chan_pkg::*;
  // An undriven pin falls to the pull-down level, never keeps the last value
  assign pin_level = chan_out & chan_oe;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      high_cnt <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        high_cnt[i] <= high_cnt[i] + 16'(pin_level[i]);
      end
    end
  end
endmodule

/* File: tb/timer_channel_compare_pwm_sva.sv */
// Port-level checker for the timer channel compare and PWM block
`timescale 1ns/1ps
module timer_channel_compare_pwm_sva (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [chan_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [chan_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [chan_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [chan_pkg::NUM_CH-1:0] chan_out,
  input wire logic [chan_pkg::NUM_CH-1:0] chan_oe,
  input wire logic [chan_pkg::NUM_CH-1:0] chan_irq,
  input wire logic overflow_flag
);
  import chan_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Shadow of the few control bits we need
  // ----------------------------------------
  logic run_s;
  logic [1:0] pair_s;
  logic [CFG_W-1:0] cfg0_s;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_s <= 1'b0;
      pair_s <= '0;
      cfg0_s <= '0;
    end else if (reg_wr) begin
      if (reg_addr == A_CTRL) run_s <= reg_wdata[0];
      if (reg_addr == A_PAIR) pair_s <= reg_wdata[1:0];
      if (reg_addr == A_CH_CFG) cfg0_s <= reg_wdata[CFG_W-1:0];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  property p_ovf_sticky;
    overflow_flag && !(reg_wr && reg_addr == A_STATUS && reg_wdata[STAT_OVF_BIT])
      |=> overflow_flag;
  endproperty
  property p_oe_by_write;
    $changed(chan_oe) |-> $past(reg_wr);
  endproperty
  property p_stop_out;
    // A register write reaches the pins one clock after it lands
    !run_s && !reg_wr && !$past(reg_wr) |=> $stable(chan_out);
  endproperty
  property p_stop_irq;
    !run_s && !reg_wr && !$past(reg_wr) |=> $stable(chan_irq) && !$rose(overflow_flag);
  endproperty
  property p_irq_en;
    !cfg0_s[4] && !$past(cfg0_s[4]) |-> !chan_irq[0];
  endproperty
  property p_irq_hold;
    chan_irq[0] && !reg_wr |=> chan_irq[0];
  endproperty
  property p_lvl_off;
    cfg0_s[1:0] == 2'b00 |-> !chan_oe[0];
  endproperty
  property p_odd_off;
    pair_s != 2'b00 |-> !chan_oe[1];
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");
  a_oe_by_write: assert property (p_oe_by_write) else $error("oe moved alone");
  a_stop_out: assert property (p_stop_out) else $error("output moved stopped");
  a_stop_irq: assert property (p_stop_irq) else $error("event while stopped");
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  a_lvl_off: assert property (p_lvl_off) else $error("oe with level 0:0");
  a_odd_off: assert property (p_odd_off) else $error("odd oe when paired");
  c_out: cover property ($rose(chan_out[0]));
  c_ovf: cover property ($rose(overflow_flag));
  c_irq: cover property ($rose(chan_irq[1]));
endmodule

/* File: tb/timer_channel_compare_pwm_bench.sv */
// Self-checking bench for the timer channel compare and PWM block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("FAIL %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module timer_channel_compare_pwm_bench;
  import chan_pkg::*;
  logic ref_clk;
  logic nrst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_CH-1:0] chan_out;
  logic [NUM_CH-1:0] chan_oe;
  logic [NUM_CH-1:0] chan_irq;
  logic overflow_flag;
  logic [NUM_CH-1:0] pin_level;
  logic [NUM_CH-1:0][15:0] high_cnt;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  timer_channel_compare_pwm dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_out(chan_out), .chan_oe(chan_oe), .chan_irq(chan_irq),
    .overflow_flag(overflow_flag));
  chan_pin_model pins (.ref_clk(ref_clk), .nrst(nrst), .chan_out(chan_out),
    .chan_oe(chan_oe), .pin_level(pin_level), .high_cnt(high_cnt));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Runaway guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Bus and measurement tasks
  // ----------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic setup(input logic [3:0][15:0] v, input logic [3:0][15:0] c);
    for (int i = 0; i < NUM_CH; i++) begin
      wr(A_CH_VAL + 5'(i), v[i]);
      wr(A_CH_CFG + 5'(i), c[i]);
    end
  endtask
  // Counts pin high cycles over n clocks once the waveform has settled
  task automatic duty(input int n, input logic [3:0][15:0] e);
    logic [3:0][15:0] a;
    repeat (12) @(posedge ref_clk);
    #1;
    a = high_cnt;
    repeat (n) @(posedge ref_clk);
    #1;
    for (int i = 0; i < NUM_CH; i++) begin
      `CHK("high_cycles", e[i], 16'(high_cnt[i] - a[i]))
    end
  endtask
  task finish_test;
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd_chk(A_STATUS, 16'h0000);
    wr(A_LIMIT, 16'h0009);
    rd_chk(A_LIMIT, 16'h0009);
    rd_chk(5'h1f, 16'h0000);
  endtask
  task automatic t_edge;
    wr(A_LIMIT, 16'h0004);
    setup({16'h2, 16'h5, 16'h0, 16'h2}, {16'h09, 16'h0a, 16'h0a, 16'h1a});
    wr(A_COUNT, 16'h0000);
    wr(A_CTRL, 16'h0001);
    duty(20, {16'd12, 16'd20, 16'd0, 16'd8});
    rd_chk(A_STATUS, 16'h0091);
    `CHK("chan_irq", 4'b0001, chan_irq)
    `CHK("overflow_flag", 1'b1, overflow_flag)
  endtask
  task automatic t_center;
    wr(A_CTRL, 16'h0000);
    wr(A_STATUS, 16'h00f1);
    wr(A_LIMIT, 16'h0008);
    setup({16'h5, 16'h8, 16'h8003, 16'h5}, {16'h01, 16'h02, 16'h02, 16'h12});
    wr(A_COUNT, 16'h0000);
    wr(A_CTRL, 16'h0003);
    duty(32, {16'd12, 16'd32, 16'd0, 16'd20});
    rd_chk(A_STATUS, 16'h0091);
  endtask
  task automatic t_compare;
    wr(A_CTRL, 16'h0000);
    wr(A_LIMIT, 16'h0007);
    setup({16'h2, 16'h2, 16'h2, 16'h3}, {16'h04, 16'h06, 16'h07, 16'h15});
    wr(A_COUNT, 16'h0000);
    wr(A_STATUS, 16'h00f1);
    #1;
    `CHK("held_out", 1'b1, chan_out[2])
    wr(A_CTRL, 16'h0001);
    duty(16, {16'd0, 16'd0, 16'd16, 16'd8});
    `CHK("chan_oe", 4'b0111, chan_oe)
    rd_chk(A_STATUS, 16'h00f1);
    `CHK("chan_irq", 4'b0001, chan_irq)
  endtask
  task automatic t_combine;
    wr(A_CTRL, 16'h0000);
    wr(A_STATUS, 16'h00f1);
    wr(A_LIMIT, 16'h0009);
    wr(A_PAIR, 16'h0005);
    setup({16'h7, 16'h3, 16'h6, 16'h2}, {16'h00, 16'h01, 16'h10, 16'h02});
    wr(A_COUNT, 16'h0000);
    wr(A_CTRL, 16'h0005);
    #1;
    `CHK("chan_oe", 4'b0101, chan_oe)
    duty(20, {16'd0, 16'd12, 16'd0, 16'd8});
    rd_chk(A_STATUS, 16'h00f1);
    `CHK("chan_irq", 4'b0010, chan_irq)
    wr(A_PAIR, 16'h0007);
    #1;
    `CHK("chan_oe", 4'b0100, chan_oe)
  endtask
  initial begin
    nrst = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_edge();
    t_center();
    t_compare();
    t_combine();
    finish_test();
  end
endmodule
bind timer_channel_compare_pwm timer_channel_compare_pwm_sva chk (.ref_clk(ref_clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_out(chan_out), .chan_oe(chan_oe),
  .chan_irq(chan_irq), .overflow_flag(overflow_flag));
